// ==== verilog/rx_cfg.svh ====
// constants for the asynchronous serial receiver
// Operation
// - a falling edge on the idle line starts a character; start bit is low
// - after half a bit recheck the line; if high, abort silently, no error
// - step one bit to each bit centre, majority vote, shift into shift register
// - one bit after last data bit sample stop; low marks framing error
// - after stop bit move character into fifo and raise pending flag
// - reading the data register returns and pops the oldest character
// - while overrun stands no further characters enter the fifo
// - pending flag high when enabled and fifo not empty; software cannot write it
// - interrupt only when receive, peripheral and global enables all set
// - fifo stores framing status per character; flag shows the oldest one
// - framing flag read-only, advances on pop, does not stop reception
// - port disable clears framing flag; receiver disable leaves it
// - framing error alone never raises an interrupt
// - fifo holds two; a third complete character sets overrun
// - fifo stays readable in overrun; overrun clears only by disabling
// - nine-bit select shifts nine bits; ninth bit field shows oldest character
// - address detect in nine-bit mode keeps only ninth-bit-high characters
// - in nine-bit address detect mode every stored character has ninth bit high
// - recovery runs on a tick at sixteen times the baud rate
// - reception active only with receiver enable, async mode and port enable
// - port enable clear holds the unit in reset except its control registers
`ifndef RX_CFG_SVH
`define RX_CFG_SVH
`define OFS_BAUD_CTRL   8'h00
`define OFS_RX_DATA     8'h04
`define OFS_RX_STAT     8'h08
`define OFS_DIV_LOW     8'h0c
`define OFS_DIV_HIGH    8'h10
`define OFS_TX_STAT     8'h14
`define OFS_IRQ_CTRL    8'h18
`define RS_PORT_EN_BIT    7
`define RS_NINE_BIT       6
`define RS_RX_EN_BIT      4
`define RS_ADDR_DET_BIT   3
`define RS_FRAME_ERR_BIT  2
`define RS_OVERRUN_BIT    1
`define RS_NINTH_BIT      0
`define TS_SYNC_BIT       4
`define TS_SPEED_BIT      2
`define BC_IDLE_BIT       6
`define BC_WIDE_BIT       3
`define IC_GLOBAL_BIT     2
`define IC_PERIPH_BIT     1
`define IC_RX_BIT         0
`define TICKS_PER_BIT   4'hf
`define TICK_HALF       4'h7
`define TICK_VOTE_A     4'h7
`define TICK_VOTE_B     4'h8
`define TICK_VOTE_C     4'h9
`define FIFO_DEPTH      2
`endif

// ==== verilog/rx_pkg.sv ====
// types for the asynchronous serial receiver
`default_nettype none
package rx_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_t;
    typedef struct packed {
        rx_state_t   st;
        logic        line_q;
        logic [15:0] tick_cnt;
        logic [3:0]  os_cnt;
        logic [3:0]  bit_idx;
        logic [8:0]  shift;
        logic [2:0]  votes;
        logic [9:0]  ent0;
        logic [9:0]  ent1;
        logic [1:0]  count;
        logic        overrun;
        logic [7:0]  rs_ctrl;
        logic [7:0]  ts_ctrl;
        logic [7:0]  bc_ctrl;
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic [2:0]  irq_ctrl;
        logic        pending;
        logic        irq;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } rx_regs_t;
endpackage
`default_nettype wire

// ==== verilog/async_serial_receiver.sv ====
// receive path of an asynchronous serial port with apb registers
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "rx_cfg.svh"
`default_nettype none
module async_serial_receiver (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        rx_line,
    output logic             rx_char_pending_flag,
    output logic             rx_irq
);
    rx_pkg::rx_regs_t r;
    rx_pkg::rx_regs_t next_r;

    logic        port_on;
    logic        rx_active;
    logic        tick;
    logic [15:0] div_val;
    logic [15:0] tick_lim;
    logic        acc;
    logic        vote;
    logic [3:0]  nbits;
    logic [8:0]  ch;
    logic        frame_err_new;
    logic        push;
    logic        pop;
    logic [9:0]  new_ent;
    logic        rd_data;
    logic [7:0]  rdv;

    assign port_on   = r.rs_ctrl[`RS_PORT_EN_BIT];
    assign rx_active = r.rs_ctrl[`RS_RX_EN_BIT] && !r.ts_ctrl[`TS_SYNC_BIT] && port_on;
    assign div_val   = r.bc_ctrl[`BC_WIDE_BIT] ? {r.div_hi, r.div_lo} : {8'h00, r.div_lo};
    assign tick_lim  = div_val;
    // one oversampling tick every divisor+1 clocks, sixteen per bit
    assign tick      = (r.tick_cnt == tick_lim);
    assign acc       = psel && penable;
    assign vote      = (r.votes[0] & r.votes[1]) | (r.votes[1] & r.votes[2])
                     | (r.votes[0] & r.votes[2]);
    assign nbits     = r.rs_ctrl[`RS_NINE_BIT] ? 4'h9 : 4'h8;

    always_comb
    begin
        next_r = r;
        ch = '0;
        frame_err_new = 1'b0;
        push = 1'b0;
        rdv = 8'h00;
        rd_data = acc && !pwrite && r.pready == 1'b0 && paddr == `OFS_RX_DATA;
        next_r.line_q = rx_line;
        next_r.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;
        next_r.pready = acc && !r.pready;
        next_r.pslverr = 1'b0;
        next_r.prdata = 32'h0000_0000;

        // receive state machine
        if (!rx_active)
        begin
            next_r.st = rx_pkg::ST_IDLE;
        end
        else
        begin
            unique case (r.st)
                rx_pkg::ST_IDLE:
                begin
                    if (r.line_q && !rx_line)
                    begin
                        next_r.st = rx_pkg::ST_START;
                        next_r.os_cnt = 4'h0;
                        next_r.tick_cnt = 16'h0000;
                    end
                end
                rx_pkg::ST_START:
                begin
                    if (tick)
                    begin
                        next_r.os_cnt = r.os_cnt + 4'h1;
                        if (r.os_cnt == `TICK_HALF)
                        begin
                            if (rx_line)
                                next_r.st = rx_pkg::ST_IDLE;
                            else
                            begin
                                next_r.st = rx_pkg::ST_DATA;
                                // the decision slot right after the centre only arms the count
                                next_r.bit_idx = 4'hf;
                                next_r.os_cnt = 4'h9;
                            end
                        end
                    end
                end
                rx_pkg::ST_DATA, rx_pkg::ST_STOP:
                begin
                    if (tick)
                    begin
                        // os_cnt 0 marks the bit's leading edge; centre at 8
                        next_r.os_cnt = r.os_cnt + 4'h1;
                        if (r.os_cnt == `TICK_VOTE_A)
                            next_r.votes[0] = rx_line;
                        if (r.os_cnt == `TICK_VOTE_B)
                            next_r.votes[1] = rx_line;
                        if (r.os_cnt == `TICK_VOTE_C)
                            next_r.votes[2] = rx_line;
                    end
                    // decide one tick after the last vote sample
                    if (tick && r.os_cnt == 4'ha && r.st == rx_pkg::ST_DATA && r.bit_idx == 4'hf)
                        next_r.bit_idx = 4'h0;
                    else if (tick && r.os_cnt == 4'ha && r.st == rx_pkg::ST_DATA)
                    begin
                        next_r.shift[r.bit_idx] = vote;
                        next_r.bit_idx = r.bit_idx + 4'h1;
                        if (r.bit_idx + 4'h1 == nbits)
                            next_r.st = rx_pkg::ST_STOP;
                    end
                    else if (tick && r.os_cnt == 4'ha)
                    begin
                        next_r.st = rx_pkg::ST_IDLE;
                        frame_err_new = !vote;
                        ch = r.rs_ctrl[`RS_NINE_BIT] ? r.shift : {1'b0, r.shift[7:0]};
                        // address filter only counts in nine-bit mode
                        if (r.rs_ctrl[`RS_ADDR_DET_BIT] && r.rs_ctrl[`RS_NINE_BIT] && !ch[8])
                            push = 1'b0; // discarded silently
                        else if (r.overrun)
                            push = 1'b0; // dropped while overrun stands
                        else if (r.count == 2'd2 && !rd_data)
                            next_r.overrun = 1'b1;
                        else
                            push = 1'b1;
                    end
                end
                default:
                    next_r.st = rx_pkg::ST_IDLE;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////////
        // fifo update; a pop and an arrival in one cycle keep the new character
        pop = rd_data && r.count != 2'd0;
        new_ent = {frame_err_new, ch};
        if (pop)
        begin
            next_r.ent0 = r.ent1;
            next_r.count = r.count - 2'd1;
        end
        if (push)
        begin
            if (next_r.count == 2'd0)
                next_r.ent0 = new_ent;
            else
                next_r.ent1 = new_ent;
            next_r.count = next_r.count + 2'd1;
        end

        // apb register access, one wait state
        if (acc && !r.pready)
        begin
            if (pwrite)
            begin
                unique case (paddr)
                    `OFS_BAUD_CTRL: next_r.bc_ctrl = {2'b00, 2'b00, pwdata[3], 3'b000};
                    `OFS_RX_STAT:   next_r.rs_ctrl = {pwdata[7:3], 3'b000};
                    `OFS_DIV_LOW:   next_r.div_lo = pwdata[7:0];
                    `OFS_DIV_HIGH:  next_r.div_hi = pwdata[7:0];
                    `OFS_TX_STAT:   next_r.ts_ctrl = {3'b000, pwdata[4], 1'b0, pwdata[2], 2'b00};
                    `OFS_IRQ_CTRL:  next_r.irq_ctrl = pwdata[2:0];
                    `OFS_RX_DATA:   next_r.pslverr = 1'b1;
                    default:        next_r.pslverr = 1'b1;
                endcase
            end
            else
            begin
                unique case (paddr)
                    `OFS_BAUD_CTRL: rdv = r.bc_ctrl | {1'b0, r.st == rx_pkg::ST_IDLE, 6'h00};
                    `OFS_RX_DATA:   rdv = r.ent0[7:0];
                    `OFS_RX_STAT:   rdv = {r.rs_ctrl[7:3], r.ent0[9] && r.count != 2'd0,
                                           r.overrun, r.ent0[8] && r.count != 2'd0};
                    `OFS_DIV_LOW:   rdv = r.div_lo;
                    `OFS_DIV_HIGH:  rdv = r.div_hi;
                    `OFS_TX_STAT:   rdv = r.ts_ctrl | 8'h02;
                    `OFS_IRQ_CTRL:  rdv = {5'h00, r.irq_ctrl};
                    default:        next_r.pslverr = 1'b1;
                endcase
                next_r.prdata = {24'h000000, rdv};
            end
        end

        // overrun cleared only by receiver or port disable
        if (!next_r.rs_ctrl[`RS_RX_EN_BIT])
            next_r.overrun = 1'b0;
        // port disabled holds everything but the control registers in reset
        if (!next_r.rs_ctrl[`RS_PORT_EN_BIT])
        begin
            next_r.count = 2'd0;
            next_r.ent0 = '0;
            next_r.ent1 = '0;
            next_r.overrun = 1'b0;
            next_r.st = rx_pkg::ST_IDLE;
        end
        next_r.pending = next_r.rs_ctrl[`RS_RX_EN_BIT] && next_r.count != 2'd0;
        // framing status has no path into the request
        next_r.irq = next_r.pending && next_r.irq_ctrl == 3'b111;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.line_q <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign pready = r.pready;
    assign prdata = r.prdata;
    assign pslverr = r.pslverr;
    assign rx_char_pending_flag = r.pending;
    assign rx_irq = r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    a_irq_needs_all: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rx_irq |-> r.irq_ctrl == 3'b111 && rx_char_pending_flag)
        else $error("irq without all enables");
    a_char_stored: assert property (@(posedge clk_sys) disable iff (sys_rst)
        r.st == rx_pkg::ST_STOP && tick && r.os_cnt == 4'ha && r.count == 2'd0 && !r.overrun
        && rx_active && !r.rs_ctrl[`RS_ADDR_DET_BIT] && !acc |=> rx_char_pending_flag)
        else $error("finished character not stored");
    a_pend_exact: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rx_char_pending_flag == (r.rs_ctrl[`RS_RX_EN_BIT] && r.count != 2'd0))
        else $error("pending does not follow fifo");
    a_ovr_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        r.overrun && r.rs_ctrl[`RS_RX_EN_BIT] && r.rs_ctrl[`RS_PORT_EN_BIT] |=> r.overrun ||
        !r.rs_ctrl[`RS_RX_EN_BIT] || !r.rs_ctrl[`RS_PORT_EN_BIT])
        else $error("overrun cleared early");
    a_ovr_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(r.overrun) |-> $past(r.count) == 2'd2)
        else $error("overrun without full fifo");
    a_ovr_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
        r.overrun |=> r.count <= $past(r.count))
        else $error("fifo grew during overrun");
    a_off_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !r.rs_ctrl[`RS_PORT_EN_BIT] |-> r.count == 2'd0 && !r.overrun)
        else $error("unit not held in reset");
    a_addr_ninth: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(r.count == 2'd1) && $past(r.rs_ctrl[`RS_ADDR_DET_BIT] && r.rs_ctrl[`RS_NINE_BIT])
        && $past(r.count) == 2'd0 |-> r.ent0[8])
        else $error("address mode stored low ninth bit");
    a_start_half: assert property (@(posedge clk_sys) disable iff (sys_rst)
        r.st == rx_pkg::ST_START && tick && r.os_cnt == `TICK_HALF && rx_line
        |=> r.st == rx_pkg::ST_IDLE && r.overrun == $past(r.overrun))
        else $error("false start not dropped");
    c_char_in: cover property (@(posedge clk_sys) $rose(rx_char_pending_flag));
    c_overrun: cover property (@(posedge clk_sys) $rose(r.overrun));
    c_framing_error_flag: cover property (@(posedge clk_sys) r.count != 2'd0 && r.ent0[9]);
    c_nine: cover property (@(posedge clk_sys) r.count != 2'd0 && r.ent0[8]);
endmodule
`default_nettype wire

// ==== dv/serial_tx_model.sv ====
// serial transmitter model driving the receive line of the block
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model #(
    parameter int BIT_CLKS = 48
) (
    input  wire logic clk_sys,
    output logic      rx_line
);
    initial rx_line = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    // stop level is the caller's choice so that framing faults can be provoked
    task automatic send(input logic [8:0] d, input int nbits, input logic stop_lvl);
        @(posedge clk_sys);
        rx_line <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk_sys);
        for (int i = 0; i < nbits; i++)
        begin
            rx_line <= d[i];
            repeat (BIT_CLKS) @(posedge clk_sys);
        end
        rx_line <= stop_lvl;
        repeat (BIT_CLKS) @(posedge clk_sys);
        rx_line <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_sys);
    endtask
    // low pulse far shorter than half a bit
    task automatic glitch();
        @(posedge clk_sys);
        rx_line <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rx_line <= 1'b1;
        repeat (2 * BIT_CLKS) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== dv/async_serial_receiver_test.sv ====
// self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ps
`include "rx_cfg.svh"
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module async_serial_receiver_test;
    localparam int DIV = 2;
    logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        rx_line, rx_char_pending_flag, rx_irq, er, ovr;
    logic [7:0]  paddr, cfgv;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  q[$];
    int          n_fail, total_checks, seed;

    async_serial_receiver dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_line(rx_line),
        .rx_char_pending_flag(rx_char_pending_flag), .rx_irq(rx_irq));
    serial_tx_model #(.BIT_CLKS(16 * (DIV + 1))) tx (.clk_sys(clk_sys), .rx_line(rx_line));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // only the watchdog ends a wait that never gets its answer
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // model keeps the fifo and overrun state alongside each control write
    task automatic cfg(input logic [7:0] v);
        apb(1'b1, `OFS_RX_STAT, {24'h0, v});
        cfgv = v;
        if (!v[7]) q.delete();
        if (!v[7] || !v[4]) ovr = 1'b0;
    endtask
    task automatic rx(input logic [8:0] d, input logic stop);
        tx.send(d, cfgv[6] ? 9 : 8, stop);
        if (!cfgv[6]) d[8] = 1'b0;
        if (ovr || (cfgv[6] && cfgv[3] && !d[8])) return;
        if (q.size() == 2) ovr = 1'b1;
        else q.push_back({!stop, d});
    endtask
    // only used while the fifo holds a character or just after a port reset
    task automatic stat();
        apb(1'b0, `OFS_RX_STAT, 32'h0);
        `CHK({rd[7:6], rd[4:0]}, {cfgv[7:6], cfgv[4:3], q.size() ? q[0][9] : 1'b0, ovr,
            q.size() ? q[0][8] : 1'b0})
    endtask
    task automatic pend();
        repeat (2) @(posedge clk_sys);
        `CHK(rx_char_pending_flag, cfgv[7] && cfgv[4] && q.size() != 0)
    endtask
    task automatic pop();
        apb(1'b0, `OFS_RX_DATA, 32'h0);
        `CHK(rd, {24'h0, q[0][7:0]})
        void'(q.pop_front());
        pend();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        test_done();
    end
    initial
    begin
        seed = 32'h8e76b771;
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        n_fail = 0;
        total_checks = 0;
        ovr = 1'b0;
        cfgv = 8'h00;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b1, `OFS_DIV_LOW, DIV);
        apb(1'b1, `OFS_IRQ_CTRL, 32'h7);
        cfg(8'h90);
        rx(9'($random(seed)), 1'b1);
        rx(9'($random(seed)), 1'b0);
        pend();
        `CHK(rx_irq, 1'b1)
        stat();
        pop();
        stat();
        pop();
        `CHK(rx_irq, 1'b0)
        tx.glitch();
        pend();
        // third whole character overruns, fourth must be dropped
        for (int i = 0; i < 4; i++) rx(9'($random(seed)), i != 1);
        stat();
        pop();
        stat();
        cfg(8'h80);
        stat();
        pend();
        cfg(8'h00);
        stat();
        cfg(8'h80);
        cfg(8'hc8);
        cfg(8'hd8);
        rx(9'h0a5, 1'b1);
        rx(9'h15a, 1'b1);
        stat();
        pop();
        cfg(8'hd0);
        rx(9'h0c3, 1'b1);
        stat();
        apb(1'b1, `OFS_IRQ_CTRL, 32'h3);
        pend();
        `CHK(rx_irq, 1'b0)
        pop();
        apb(1'b0, 8'h1c, 32'h0);
        `CHK(er, 1'b1)
        apb(1'b1, `OFS_RX_DATA, 32'h55);
        `CHK(er, 1'b1)
        test_done();
    end
endmodule
`default_nettype wire
